//--- core/csrb_core.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module csrb_core
   import csrb_pkg::*;
#(
   parameter int PRESCALE = 256
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [AXI_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic op_valid,
   input wire logic [3:0] op_kind,
   input wire logic [JMP_W-1:0] op_imm,
   output logic op_ready,
   output logic [PC_W-1:0] pc,
   input wire logic [PC_W-1:0] stack_top,
   output logic stack_push,
   output logic stack_pop,
   output logic [PC_W-1:0] push_addr,
   input wire logic [7:0] working_register,
   output logic working_restore_valid,
   output logic [7:0] working_restore,
   input wire logic alu_flag_we,
   input wire logic alu_zero,
   input wire logic alu_half_carry,
   input wire logic alu_carry,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [DADDR_W-1:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   output logic cpu_ack,
   output logic [7:0] cpu_rdata,
   output logic mem_req,
   output logic mem_we,
   output logic [MADDR_W-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic wdt_timeout,
   input wire logic sleep_release_pin,
   output logic prescale_clear,
   output logic low_power_active,
   output logic low_power_sleep
);
   localparam logic [7:0] PRESC_LAST = 8'(PRESCALE - 1);

   csrb_st_t st_q, st_d;
   logic [3:0] cnt_q;
   logic [7:0] tcc_q, presc_q;
   logic [PC_W-1:0] pc_q;
   logic [1:0] sbank_q;
   logic to_q, pd_q, z_q, dc_q, c_q;
   logic [7:0] rsel_q;
   logic [PAGE_W-1:0] page_q;
   logic sis_q, rem_q, cyc4_q;
   logic [1:0] sh_bank_q;
   logic [2:0] sh_flag_q;
   logic [PAGE_W-1:0] sh_page_q;
   logic [7:0] sh_acc_q;
   logic rel_s1_q, rel_s2_q, rel_s3_q;
   logic aw_have_q, w_have_q;
   logic [3:0] aw_idx_q;
   logic [7:0] w_dat_q;
   logic w_lane_q;
   logic op_ready_q, stack_push_q, stack_pop_q, wr_valid_q;
   logic [PC_W-1:0] push_addr_q;
   logic [7:0] wr_restore_q;
   logic cpu_ack_q, mem_req_q, mem_we_q;
   logic [7:0] cpu_rdata_q, mem_wdata_q;
   logic [MADDR_W-1:0] mem_addr_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [7:0] rdata_q;
   logic presc_clr_q, lp_active_q, lp_sleep_q;

   // Decoding for the bus, the data port and the instruction sequencer
   function automatic logic is_core(input logic [5:0] a, input logic [1:0] bank);
      is_core = (a < DA_SPC) || (a == DA_SPC && bank == 2'b00);
   endfunction : is_core

   function automatic logic [MADDR_W-1:0] phys(input logic [5:0] a,
                                               input logic [1:0] sb,
                                               input logic [1:0] gb);
      if (a >= DA_GP) begin
         phys = {gb, a};
      end else if (a >= DA_COMMON) begin
         phys = {2'b00, a};
      end else begin
         phys = {sb, a};
      end
   endfunction : phys

   function automatic logic mapped(input logic [3:0] idx);
      mapped = (idx <= REG_STATE);
   endfunction : mapped

   function automatic logic [3:0] cyc_len(input logic four, input logic [3:0] k);
      logic [3:0] base;
      base = four ? CYC_LONG : CYC_SHORT;
      if (k == OP_JUMP || k == OP_CALL || k == OP_RET || k == OP_IRET ||
          k == OP_PCMOD || k == OP_IRQ) begin
         cyc_len = 4'(base << 1);
      end else begin
         cyc_len = base;
      end
   endfunction : cyc_len

   function automatic logic [7:0] rd_reg(input logic [3:0] idx);
      unique case (idx)
         REG_TCC: rd_reg = tcc_q;
         REG_PCL: rd_reg = pc_q[7:0];
         REG_STAT: rd_reg = {sbank_q, 1'b0, to_q, pd_q, z_q, dc_q, c_q};
         REG_RSEL: rd_reg = rsel_q;
         REG_SPC: rd_reg = {1'b0, page_q, SPC_FIXED[3:2], sis_q, rem_q};
         REG_CTRL: rd_reg = {7'h00, cyc4_q};
         REG_STATE: rd_reg = {pc_q[12:8], 1'b0, lp_sleep_q, lp_active_q};
         default: rd_reg = 8'h00;
      endcase
   endfunction : rd_reg

   // Data port decode with indirect redirection
   logic [5:0] eff_addr;
   logic cpu_int, cpu_mem, cpu_wr_int;
   assign eff_addr = (cpu_addr == {2'b00, REG_IND}) ? rsel_q[5:0] : cpu_addr;
   assign cpu_int = cpu_req && is_core(eff_addr, sbank_q);
   assign cpu_mem = cpu_req && !is_core(eff_addr, sbank_q);
   assign cpu_wr_int = cpu_int && cpu_we;

   // One write path into the core registers, data port first
   logic axi_wr_go, wr_go;
   logic [3:0] wr_idx;
   logic [7:0] wr_dat;
   assign axi_wr_go = aw_have_q && w_have_q && !bvalid_q && !cpu_wr_int;
   assign wr_go = cpu_wr_int || (axi_wr_go && w_lane_q);
   assign wr_idx = cpu_wr_int ? {1'b0, eff_addr[2:0]} : aw_idx_q;
   assign wr_dat = cpu_wr_int ? cpu_wdata : w_dat_q;

   logic op_go;
   logic wake;
   assign op_go = op_valid && op_ready_q;
   assign wake = rem_q ? rel_s2_q : (rel_s2_q && !rel_s3_q);

   // Instruction sequencer
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_READY: begin
            if (op_go && op_kind == OP_SLEEP) begin
               st_d = ST_SLEEP;
            end else if (op_go) begin
               st_d = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (cnt_q == 4'd1) begin
               st_d = ST_READY;
            end
         end
         ST_SLEEP: begin
            if (wake) begin
               st_d = ST_READY;
            end
         end
         default: st_d = ST_READY;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_READY;
         op_ready_q <= 1'b0;
         cnt_q <= 4'd0;
      end else begin
         st_q <= st_d;
         op_ready_q <= (st_d == ST_READY);
         if (op_go) begin
            cnt_q <= 4'(cyc_len(cyc4_q, op_kind) - 4'd1);
         end else if (st_q == ST_BUSY) begin
            cnt_q <= 4'(cnt_q - 4'd1);
         end
      end
   end

   // Program counter and stack handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_q <= '0;
         stack_push_q <= 1'b0;
         stack_pop_q <= 1'b0;
         push_addr_q <= '0;
      end else begin
         stack_push_q <= 1'b0;
         stack_pop_q <= 1'b0;
         if (wr_go && wr_idx == REG_PCL) begin
            pc_q <= {page_q, 2'b00, wr_dat};
         end else if (op_go) begin
            unique case (op_kind)
               OP_JUMP: pc_q <= {page_q, op_imm};
               OP_CALL: begin
                  pc_q <= {page_q, op_imm};
                  stack_push_q <= 1'b1;
                  push_addr_q <= 13'(pc_q + 13'd1);
               end
               OP_RET, OP_IRET: begin
                  pc_q <= stack_top;
                  stack_pop_q <= 1'b1;
               end
               OP_IRQ: begin
                  pc_q <= {3'b000, op_imm};
                  stack_push_q <= 1'b1;
                  push_addr_q <= pc_q;
               end
               OP_PCMOD: pc_q <= pc_q;
               default: pc_q <= 13'(pc_q + 13'd1);
            endcase
         end
      end
   end

   // Interrupt context save and restore
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sh_bank_q <= 2'b00;
         sh_flag_q <= 3'b000;
         sh_page_q <= '0;
         sh_acc_q <= RST_BYTE;
         wr_valid_q <= 1'b0;
         wr_restore_q <= RST_BYTE;
      end else begin
         wr_valid_q <= 1'b0;
         if (op_go && op_kind == OP_IRQ) begin
            sh_bank_q <= sbank_q;
            sh_flag_q <= {z_q, dc_q, c_q};
            sh_page_q <= page_q;
            sh_acc_q <= working_register;
         end
         if (op_go && op_kind == OP_IRET) begin
            wr_valid_q <= 1'b1;
            wr_restore_q <= sh_acc_q;
         end
      end
   end

   // Status flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sbank_q <= 2'b00;
         z_q <= 1'b0;
         dc_q <= 1'b0;
         c_q <= 1'b0;
      end else begin
         if (op_go && op_kind == OP_IRET) begin
            sbank_q <= sh_bank_q;
            {z_q, dc_q, c_q} <= sh_flag_q;
         end else if (wr_go && wr_idx == REG_STAT) begin
            sbank_q <= wr_dat[SR_BANK_HI:SR_BANK_LO];
            z_q <= wr_dat[SR_Z];
            dc_q <= wr_dat[SR_DC];
            c_q <= wr_dat[SR_C];
         end
         if (alu_flag_we) begin
            z_q <= alu_zero;
            dc_q <= alu_half_carry;
            c_q <= alu_carry;
         end
      end
   end

   // Timeout and power-down bits; setting wins over the timeout
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         to_q <= RST_TO;
         pd_q <= RST_PD;
      end else begin
         if (wdt_timeout) begin
            to_q <= 1'b0;
         end
         if (op_go && op_kind == OP_SLEEP) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
         end else if (op_go && op_kind == OP_WATCHDOG_CLEAR_OP) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
         end
      end
   end

   // RAM select, page and control bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsel_q <= RST_BYTE;
         page_q <= '0;
         sis_q <= 1'b0;
         rem_q <= 1'b0;
         cyc4_q <= 1'b0;
      end else begin
         if (wr_go && wr_idx == REG_RSEL) begin
            rsel_q <= wr_dat;
         end
         if (op_go && op_kind == OP_IRET) begin
            page_q <= sh_page_q;
         end else if (wr_go && wr_idx == REG_SPC) begin
            page_q <= wr_dat[SPC_PAGE_HI:SPC_PAGE_LO];
            sis_q <= wr_dat[SPC_SIS];
            rem_q <= wr_dat[SPC_REM];
         end
         if (wr_go && wr_idx == REG_CTRL) begin
            cyc4_q <= wr_dat[0];
         end
      end
   end

   // Time clock counter and its prescaler
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tcc_q <= RST_BYTE;
         presc_q <= 8'h00;
         presc_clr_q <= 1'b0;
      end else begin
         presc_clr_q <= 1'b0;
         if (wr_go && wr_idx == REG_TCC) begin
            tcc_q <= wr_dat;
            presc_q <= 8'h00;
            presc_clr_q <= 1'b1;
         end else if (presc_q == PRESC_LAST) begin
            presc_q <= 8'h00;
            tcc_q <= 8'(tcc_q + 8'd1);
         end else begin
            presc_q <= 8'(presc_q + 8'd1);
         end
      end
   end

   // Wake pin synchroniser and low-power state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rel_s1_q <= 1'b0;
         rel_s2_q <= 1'b0;
         rel_s3_q <= 1'b0;
         lp_active_q <= 1'b0;
         lp_sleep_q <= 1'b0;
      end else begin
         rel_s1_q <= sleep_release_pin;
         rel_s2_q <= rel_s1_q;
         rel_s3_q <= rel_s2_q;
         if (op_go && op_kind == OP_SLEEP) begin
            lp_active_q <= 1'b1;
            lp_sleep_q <= sis_q;
         end else if (st_q == ST_SLEEP && wake) begin
            lp_active_q <= 1'b0;
            lp_sleep_q <= 1'b0;
         end
      end
   end

   // Data port toward banked memory
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_addr_q <= '0;
         mem_wdata_q <= 8'h00;
         cpu_ack_q <= 1'b0;
         cpu_rdata_q <= 8'h00;
      end else begin
         mem_req_q <= cpu_mem;
         mem_we_q <= cpu_mem && cpu_we;
         if (cpu_mem) begin
            mem_addr_q <= phys(eff_addr, sbank_q, rsel_q[7:6]);
            mem_wdata_q <= cpu_wdata;
         end
         cpu_ack_q <= cpu_int || mem_req_q;
         if (mem_req_q) begin
            cpu_rdata_q <= mem_rdata;
         end else if (cpu_int) begin
            cpu_rdata_q <= rd_reg({1'b0, eff_addr[2:0]});
         end
      end
   end

   // Bus write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_idx_q <= 4'h0;
         awready_q <= 1'b0;
         w_have_q <= 1'b0;
         w_dat_q <= 8'h00;
         w_lane_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (awvalid && awready_q) begin
            aw_have_q <= 1'b1;
            aw_idx_q <= awaddr[5:2];
            awready_q <= 1'b0;
         end else if (!aw_have_q && !bvalid_q) begin
            awready_q <= 1'b1;
         end
         if (wvalid && wready_q) begin
            w_have_q <= 1'b1;
            w_dat_q <= wdata[7:0];
            w_lane_q <= wstrb[0];
            wready_q <= 1'b0;
         end else if (!w_have_q && !bvalid_q) begin
            wready_q <= 1'b1;
         end
         if (axi_wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Bus read channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 8'h00;
         rresp_q <= RESP_OKAY;
      end else begin
         if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_reg(araddr[5:2]);
            rresp_q <= mapped(araddr[5:2]) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end else if (!rvalid_q) begin
            arready_q <= 1'b1;
         end
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = {24'h000000, rdata_q};
   assign rresp = rresp_q;
   assign op_ready = op_ready_q;
   assign pc = pc_q;
   assign stack_push = stack_push_q;
   assign stack_pop = stack_pop_q;
   assign push_addr = push_addr_q;
   assign working_restore_valid = wr_valid_q;
   assign working_restore = wr_restore_q;
   assign cpu_ack = cpu_ack_q;
   assign cpu_rdata = cpu_rdata_q;
   assign mem_req = mem_req_q;
   assign mem_we = mem_we_q;
   assign mem_addr = mem_addr_q;
   assign mem_wdata = mem_wdata_q;
   assign prescale_clear = presc_clr_q;
   assign low_power_active = lp_active_q;
   assign low_power_sleep = lp_sleep_q;

endmodule : csrb_core

//--- core/csrb_pkg.sv
package csrb_pkg;
   // Widths
   localparam int PC_W = 13;
   localparam int PAGE_W = 3;
   localparam int JMP_W = 10;
   localparam int DADDR_W = 6;
   localparam int MADDR_W = 8;
   localparam int AXI_AW = 6;
   localparam int ROM_WORDS = 8192;
   localparam int PAGE_WORDS = 1024;
   // Register indices; byte address is four times the index
   localparam logic [3:0] REG_IND = 4'h0;
   localparam logic [3:0] REG_TCC = 4'h1;
   localparam logic [3:0] REG_PCL = 4'h2;
   localparam logic [3:0] REG_STAT = 4'h3;
   localparam logic [3:0] REG_RSEL = 4'h4;
   localparam logic [3:0] REG_SPC = 4'h5;
   localparam logic [3:0] REG_CTRL = 4'h6;
   localparam logic [3:0] REG_STATE = 4'h7;
   // Data address map
   localparam logic [5:0] DA_SPC = 6'h05;
   localparam logic [5:0] DA_BANK_LO = 6'h05;
   localparam logic [5:0] DA_COMMON = 6'h10;
   localparam logic [5:0] DA_GP = 6'h20;
   // Status field positions
   localparam int SR_BANK_HI = 7;
   localparam int SR_BANK_LO = 6;
   localparam int SR_TO = 4;
   localparam int SR_PD = 3;
   localparam int SR_Z = 2;
   localparam int SR_DC = 1;
   localparam int SR_C = 0;
   // System page control field positions and fixed bits
   localparam int SPC_PAGE_HI = 6;
   localparam int SPC_PAGE_LO = 4;
   localparam int SPC_SIS = 1;
   localparam int SPC_REM = 0;
   localparam logic [7:0] SPC_FIXED = 8'h04;
   // Reset values
   localparam logic RST_TO = 1'b1;
   localparam logic RST_PD = 1'b1;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Instruction cycle lengths in core clocks
   localparam logic [3:0] CYC_SHORT = 4'd2;
   localparam logic [3:0] CYC_LONG = 4'd4;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [3:0] {
      OP_NEXT = 4'h0, OP_JUMP = 4'h1, OP_CALL = 4'h2, OP_RET = 4'h3,
      OP_IRET = 4'h4, OP_PCMOD = 4'h5, OP_SLEEP = 4'h6, OP_WATCHDOG_CLEAR_OP = 4'h7,
      OP_IRQ = 4'h8
   } csrb_op_t;
   typedef enum logic [1:0] {
      ST_READY = 2'b00, ST_BUSY = 2'b01, ST_SLEEP = 2'b11
   } csrb_st_t;
endpackage : csrb_pkg

//--- sim/csrb_core_sva.sv
`timescale 1ns/1ps
module csrb_core_sva
   import csrb_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic op_valid,
   input wire logic [3:0] op_kind,
   input wire logic [JMP_W-1:0] op_imm,
   input wire logic op_ready,
   input wire logic [PC_W-1:0] pc,
   input wire logic [PC_W-1:0] stack_top,
   input wire logic stack_push,
   input wire logic stack_pop,
   input wire logic [PC_W-1:0] push_addr,
   input wire logic cpu_req,
   input wire logic [DADDR_W-1:0] cpu_addr,
   input wire logic mem_req,
   input wire logic [MADDR_W-1:0] mem_addr,
   input wire logic low_power_active
);
   logic take;
   assign take = op_valid && op_ready;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   pc_reset_zero_a: assert property (disable iff (1'b0) !aresetn |=> pc == '0)
      else $error("pc not cleared by reset");
   jump_low_bits_a: assert property (take && op_kind == OP_JUMP |=> pc[9:0] == $past(op_imm))
      else $error("jump target wrong");
   ret_from_stack_a: assert property (take && (op_kind == OP_RET || op_kind == OP_IRET)
      |=> stack_pop && pc == $past(stack_top))
      else $error("return target wrong");
   irq_vector_a: assert property (take && op_kind == OP_IRQ
      |=> stack_push && push_addr == $past(pc) && pc == {3'b000, $past(op_imm)})
      else $error("interrupt vector wrong");
   call_push_a: assert property (take && op_kind == OP_CALL
      |=> stack_push && push_addr == $past(pc) + 13'h1)
      else $error("call return address wrong");
   long_cycle_a: assert property (take && op_kind == OP_JUMP |=> !op_ready [*3])
      else $error("jump too short");
   common_map_a: assert property (cpu_req && cpu_addr[5:4] == 2'b01
      |=> mem_req && mem_addr == {2'b00, $past(cpu_addr)})
      else $error("common area address wrong");
   gp_map_a: assert property (cpu_req && cpu_addr[5]
      |=> mem_req && mem_addr[5:0] == $past(cpu_addr))
      else $error("bank offset wrong");
   sleep_enter_a: assert property (take && op_kind == OP_SLEEP |=> ##[0:3] low_power_active)
      else $error("power down not entered");
endmodule : csrb_core_sva
bind csrb_core csrb_core_sva csrb_core_sva_i (.aclk, .aresetn, .op_valid, .op_kind, .op_imm,
   .op_ready, .pc, .stack_top, .stack_push, .stack_pop, .push_addr, .cpu_req, .cpu_addr,
   .mem_req, .mem_addr, .low_power_active);

//--- sim/csrb_far_model.sv
`timescale 1ns/1ps
module csrb_far_model
   import csrb_pkg::*;
(
   input wire logic aclk,
   input wire logic stack_push,
   input wire logic stack_pop,
   input wire logic [PC_W-1:0] push_addr,
   output logic [PC_W-1:0] stack_top,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [MADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [256];
   logic [PC_W-1:0] stk [8];
   logic [2:0] sp_q;
   logic [7:0] last_q;
   initial begin
      sp_q = 3'h0;
      last_q = 8'h00;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
         stk[i%8] = '0;
      end
   end
   // Idle bus shows the inverse of the last value
   assign mem_rdata = mem_req ? mem[mem_addr] : ~last_q;
   assign stack_top = stk[sp_q-3'h1];
   always @(posedge aclk) begin
      if (mem_req) last_q <= mem[mem_addr];
      if (mem_req && mem_we) mem[mem_addr] <= mem_wdata;
      if (stack_push) begin
         stk[sp_q] <= push_addr;
         sp_q <= sp_q + 3'h1;
      end else if (stack_pop) sp_q <= sp_q - 3'h1;
   end
endmodule : csrb_far_model

//--- sim/csrb_core_tb.sv
`timescale 1ns/1ps
module csrb_core_tb;
   import csrb_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, op_valid, op_ready, stack_push, stack_pop;
   logic working_restore_valid, alu_flag_we, alu_zero, alu_half_carry, alu_carry;
   logic cpu_req, cpu_we, cpu_ack, mem_req, mem_we, wdt_timeout, sleep_release_pin;
   logic prescale_clear, low_power_active, low_power_sleep, pcl_seen;
   logic [5:0] awaddr, araddr, cpu_addr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, op_kind;
   logic [1:0] bresp, rresp;
   logic [9:0] op_imm;
   logic [12:0] pc, stack_top, push_addr, pushed;
   logic [7:0] working_register, working_restore, cpu_wdata, cpu_rdata;
   logic [7:0] mem_wdata, mem_rdata, mem_addr, restored;
   int bad_count, n_checks;
   csrb_core #(.PRESCALE(64)) csrb_core_i (.*);
   csrb_far_model csrb_far_model_i (.*);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) if (prescale_clear) pcl_seen <= 1'b1;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", er, bresp);
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [3:0] idx, input logic [7:0] e, input logic [1:0] er);
      araddr <= {idx, 2'b00};
      {arvalid, rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rdata", e, rdata);
      chk("rresp", er, rresp);
      @(posedge aclk);
   endtask : rd
   task automatic op(input csrb_op_t k, input logic [9:0] imm, input int lat);
      int n;
      op_valid <= 1'b1;
      op_kind <= k;
      op_imm <= imm;
      do @(posedge aclk); while (!op_ready);
      op_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (stack_push) pushed = push_addr;
         if (working_restore_valid) restored = working_restore;
      end while (!op_ready);
      if (lat > 0) chk("latency", lat, n);
   endtask : op
   task automatic cpu(input logic we, input logic [5:0] a, input logic [7:0] d,
         input logic [7:0] ema, input logic [7:0] erd);
      {cpu_req, cpu_we} <= {1'b1, we};
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge aclk);
      cpu_req <= 1'b0;
      do begin
         @(posedge aclk);
         if (mem_req) chk("mem_addr", ema, mem_addr);
      end while (!cpu_ack);
      if (!we) chk("cpu_rdata", erd, cpu_rdata);
   endtask : cpu
   task automatic t_reset;
      chk("pc", 13'h0, pc);
      rd(REG_STAT, 8'h18, RESP_OKAY);
      rd(REG_SPC, 8'h04, RESP_OKAY);
   endtask : t_reset
   task automatic t_regs;
      wr(REG_RSEL, 8'ha5, RESP_OKAY);
      rd(REG_RSEL, 8'ha5, RESP_OKAY);
      wr(REG_STAT, 8'hff, RESP_OKAY);
      rd(REG_STAT, 8'hdf, RESP_OKAY);
      wr(REG_STAT, 8'h80, RESP_OKAY);
      rd(REG_STAT, 8'h98, RESP_OKAY);
      wr(REG_SPC, 8'hff, RESP_OKAY);
      rd(REG_SPC, 8'h77, RESP_OKAY);
      wr(4'h8, 8'h11, RESP_SLVERR);
      rd(4'h8, 8'h00, RESP_SLVERR);
      rd(REG_IND, 8'h00, RESP_OKAY);
   endtask : t_regs
   task automatic t_tcc;
      pcl_seen = 1'b0;
      wr(REG_TCC, 8'h55, RESP_OKAY);
      @(posedge aclk);
      chk("prescale_clear", 1'b1, pcl_seen);
      rd(REG_TCC, 8'h55, RESP_OKAY);
      repeat (70) @(posedge aclk);
      rd(REG_TCC, 8'h56, RESP_OKAY);
      pcl_seen = 1'b0;
      cpu(1'b1, 6'h01, 8'h10, 8'h00, 8'h00);
      @(posedge aclk);
      chk("prescale_clear", 1'b1, pcl_seen);
   endtask : t_tcc
   task automatic t_flow;
      wr(REG_SPC, 8'h34, RESP_OKAY);
      op(OP_JUMP, 10'h2aa, 4);
      chk("pc", 13'h0eaa, pc);
      op(OP_NEXT, 10'h0, 2);
      op(OP_CALL, 10'h010, 4);
      chk("push_addr", 13'h0eac, pushed);
      chk("pc", 13'h0c10, pc);
      wr(REG_SPC, 8'h54, RESP_OKAY);
      op(OP_RET, 10'h0, 4);
      chk("pc", 13'h0eac, pc);
      rd(REG_SPC, 8'h54, RESP_OKAY);
      wr(REG_CTRL, 8'h01, RESP_OKAY);
      op(OP_NEXT, 10'h0, 4);
      wr(REG_CTRL, 8'h00, RESP_OKAY);
      op(OP_PCMOD, 10'h0, 4);
      chk("pc", 13'h0ead, pc);
   endtask : t_flow
   task automatic t_irq;
      op(OP_IRQ, 10'h008, 4);
      chk("push_addr", 13'h0ead, pushed);
      chk("pc", 13'h0008, pc);
      wr(REG_SPC, 8'h14, RESP_OKAY);
      wr(REG_STAT, 8'h00, RESP_OKAY);
      working_register <= 8'h00;
      op(OP_IRET, 10'h0, 4);
      chk("pc", 13'h0ead, pc);
      chk("working_restore", 8'h3c, restored);
      rd(REG_SPC, 8'h54, RESP_OKAY);
      rd(REG_STAT, 8'h98, RESP_OKAY);
   endtask : t_irq
   task automatic t_data;
      cpu(1'b0, 6'h00, 8'h00, 8'ha5, 8'hff);
      cpu(1'b0, 6'h13, 8'h00, 8'h13, 8'h49);
      cpu(1'b0, 6'h07, 8'h00, 8'h87, 8'hdd);
      cpu(1'b1, 6'h30, 8'h66, 8'hb0, 8'h00);
      cpu(1'b0, 6'h30, 8'h00, 8'hb0, 8'h66);
      {alu_flag_we, alu_zero, alu_half_carry, alu_carry} <= 4'b1101;
      @(posedge aclk);
      alu_flag_we <= 1'b0;
      rd(REG_STAT, 8'h9d, RESP_OKAY);
   endtask : t_data
   task automatic t_power;
      wr(REG_SPC, 8'h56, RESP_OKAY);
      fork
         op(OP_SLEEP, 10'h0, 0);
         begin
            repeat (6) @(posedge aclk);
            chk("low_power_active", 1'b1, low_power_active);
            chk("low_power_sleep", 1'b1, low_power_sleep);
            rd(REG_STAT, 8'h95, RESP_OKAY);
            sleep_release_pin <= 1'b1;
         end
      join
      sleep_release_pin <= 1'b0;
      op(OP_WATCHDOG_CLEAR_OP, 10'h0, 2);
      rd(REG_STAT, 8'h9d, RESP_OKAY);
      wdt_timeout <= 1'b1;
      @(posedge aclk);
      wdt_timeout <= 1'b0;
      rd(REG_STAT, 8'h8d, RESP_OKAY);
      wr(REG_SPC, 8'h55, RESP_OKAY);
      sleep_release_pin <= 1'b1;
      op(OP_SLEEP, 10'h0, 0);
      rd(REG_STAT, 8'h95, RESP_OKAY);
      wr(REG_PCL, 8'h3c, RESP_OKAY);
      chk("pc", 13'h143c, pc);
      rd(REG_STATE, 8'ha0, RESP_OKAY);
   endtask : t_power
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      #2000000;
      bad_count++;
      give_verdict;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, op_valid, cpu_req, cpu_we} = '0;
      {alu_flag_we, alu_zero, alu_half_carry, alu_carry, wdt_timeout} = '0;
      {sleep_release_pin, pcl_seen, awaddr, araddr, cpu_addr, wdata, op_kind, op_imm} = '0;
      {cpu_wdata, pushed, restored, bad_count, n_checks} = '0;
      wstrb = 4'hf;
      working_register = 8'h3c;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset;
      t_regs;
      t_tcc;
      t_flow;
      t_irq;
      t_data;
      t_power;
      give_verdict;
   end
endmodule : csrb_core_tb
